// [rtl/cpo_pkg.sv]
package cpo_pkg;
    // number of counter units on the board
    localparam int CPO_UNITS = 4;
    // counter width
    localparam int CPO_WIDTH = 16;
    // register byte offsets (three registers in a block of four words per unit)
    localparam logic [7:0] CPO_OFF_CTRL = 8'h00;
    localparam logic [7:0] CPO_OFF_DIV = 8'h04;
    localparam logic [7:0] CPO_OFF_ACT = 8'h08;
    localparam logic [7:0] CPO_UNIT_STRIDE = 8'h10;
    // control field positions
    localparam int CPO_F_EN = 0;
    localparam int CPO_F_MODE = 1;
    localparam int CPO_F_GATE = 3;
    localparam int CPO_F_POL = 6;
    localparam int CPO_F_CLKSRC = 7;
    localparam int CPO_F_RUN = 8;
    localparam int CPO_F_DONE = 9;
    // reset values
    localparam logic [15:0] CPO_DIV_RST = 16'h0002;
    localparam logic [15:0] CPO_ACT_RST = 16'h0001;
    // internal counter clock divider from pclk
    localparam int CPO_PCLK_HZ = 25000000;
    localparam int CPO_INT_HZ = 5000000;
    localparam logic [7:0] CPO_INT_DIV = 8'(CPO_PCLK_HZ / CPO_INT_HZ);

    // pulse modes
    typedef enum logic [1:0]
    {
        CPO_RATE = 2'b00,
        CPO_ONESHOT = 2'b01,
        CPO_REPEAT = 2'b10
    } cpo_mode_t;

    // gate types
    typedef enum logic [2:0]
    {
        CPO_GATE_NONE = 3'b000,
        CPO_GATE_LOW = 3'b001,
        CPO_GATE_HIGH = 3'b010,
        CPO_GATE_FALL = 3'b011,
        CPO_GATE_RISE = 3'b100
    } cpo_gate_t;

    // software configuration of one unit
    typedef struct packed
    {
        logic enable;
        cpo_mode_t mode;
        cpo_gate_t gate;
        logic pol_high;
        logic ext_clk;
        logic [15:0] divider;
        logic [15:0] active;
    } cpo_cfg_t;

    // status back from one unit
    typedef struct packed
    {
        logic running;
        logic done;
    } cpo_stat_t;
endpackage

// [rtl/cpo_sync.sv]
`timescale 1ns/1ns
// two-flop synchroniser with edge detect on the second stage output
module cpo_sync
    import cpo_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw pin and clean outputs
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    // all state in one struct
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
    } cpo_sync_st_t;

    cpo_sync_st_t st;
    cpo_sync_st_t next_st;

    // shift chain; s1 is read only by s2
    always_comb
    begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    // edges are taken between second and third stage
    assign level = st.s2;
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
endmodule

// [rtl/cpo_unit.sv]
`timescale 1ns/1ns
// one 16-bit pulse output counter
module cpo_unit
    import cpo_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration and status
    input wire cpo_cfg_t cfg,
    input wire logic stop,
    output cpo_stat_t stat,
    // counting tick and gate events, already synchronised
    input wire logic tick,
    input wire logic gate_level,
    input wire logic gate_rise,
    input wire logic gate_fall,
    // pulse output
    output logic pulse_out
);
    typedef struct packed
    {
        logic busy;
        logic done;
        logic out_act;
        logic [15:0] cnt;
        logic outq;
    } cpo_unit_st_t;

    cpo_unit_st_t st;
    cpo_unit_st_t next_st;
    logic trig;
    logic gate_open;
    logic [15:0] len;

    // edge triggers for pulse modes
    // R13: edge gate start
    always_comb
    begin
        case (cfg.gate)
            CPO_GATE_RISE: trig = gate_rise;
            CPO_GATE_FALL: trig = gate_fall;
            CPO_GATE_NONE: trig = 1'b1;
            default: trig = 1'b0;
        endcase
        case (cfg.gate)
            CPO_GATE_LOW: gate_open = ~gate_level;
            CPO_GATE_HIGH: gate_open = gate_level;
            default: gate_open = 1'b1;
        endcase
    end

    // R4: one-shot full width
    // R8: repeat full width
    assign len = (cfg.divider == 16'h0000) ? 16'h0001 : cfg.divider;

    always_comb
    begin
        next_st = st;
        if (!cfg.enable || stop)
        begin
            // R15: disabled stops output
            next_st.busy = 1'b0;
            next_st.out_act = 1'b0;
            next_st.cnt = '0;
            if (!cfg.enable)
                next_st.done = 1'b0;
        end
        else
        begin
            case (cfg.mode)
                CPO_RATE:
                begin
                    // R15: continuous rate
                    if (tick && gate_open)
                    begin
                        next_st.cnt = (st.cnt + 16'h0001 >= len) ? 16'h0000
                            : st.cnt + 16'h0001;
                        next_st.out_act = (next_st.cnt < cfg.active);
                    end
                end
                CPO_ONESHOT, CPO_REPEAT:
                begin
                    // R9: triggers ignored while busy
                    // R3: ignore after done
                    if (!st.busy && !st.done && trig)
                    begin
                        // R1: one pulse on trigger
                        // R7: pulse every trigger
                        next_st.busy = 1'b1;
                        next_st.out_act = 1'b1;
                        next_st.cnt = '0;
                    end
                    else if (st.busy && tick)
                    begin
                        // R5: length from counter clock
                        if (st.cnt + 16'h0001 >= len)
                        begin
                            next_st.busy = 1'b0;
                            next_st.out_act = 1'b0;
                            next_st.cnt = '0;
                            // R2: stop after one pulse
                            // R10: repeat until stopped
                            next_st.done = (cfg.mode == CPO_ONESHOT);
                        end
                        else
                            next_st.cnt = st.cnt + 16'h0001;
                    end
                end
                default: next_st.out_act = 1'b0;
            endcase
        end
        // R6: polarity select
        // R14: active level by type
        next_st.outq = next_st.out_act ? cfg.pol_high : ~cfg.pol_high;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        // output rests at the idle level of the reset pulse type (high-to-low),
        // so leaving reset does not show a false edge on the pin
        if (!presetn)
            st <= '{outq: 1'b1, default: '0};
        else
            st <= next_st;
    end

    assign pulse_out = st.outq;
    assign stat = '{running: st.busy | (cfg.enable & cfg.mode == CPO_RATE), done: st.done};

    // one-shot stays done until disabled
    // R3: ignore after done
    a_oneshot_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (st.done && cfg.enable && !stop && cfg.mode == CPO_ONESHOT) |=> !st.busy && st.done)
        else $error("one-shot restarted after completion");
    // a busy pulse is not retriggered
    a_busy_no_restart: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (st.busy && !tick && cfg.enable && !stop && cfg.mode != CPO_RATE)
        |=> st.busy && st.cnt == $past(st.cnt))
        else $error("pulse counter disturbed by trigger");
    // trigger starts a pulse
    a_trig_start: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (!st.busy && !st.done && trig && cfg.enable && !stop && cfg.mode != CPO_RATE)
        |=> st.busy && pulse_out == $past(cfg.pol_high))
        else $error("trigger did not start pulse");
    // disable idles the output
    a_disable_idle: assert property (@(posedge pclk) disable iff (!presetn) // R15
        (!cfg.enable) [*2] |-> pulse_out == ~$past(cfg.pol_high))
        else $error("output active while disabled");
endmodule

// [rtl/cpo_top.sv]
`timescale 1ns/1ns
// Function
// R1: one-shot emits one pulse on trigger
// R2: one-shot stops after its pulse
// R3: finished one-shot ignores clock and gate
// R4: one-shot width forced full
// R5: pulse length from counter clock
// R6: one-shot polarity selectable
// R7: repeat mode pulses on each trigger
// R8: repeat mode width forced full
// R9: triggers during pulse are dropped
// R10: repeat runs until software stops
// R11: repeat polarity, clock, gate selectable
// R12: four independent counter units
// R13: edge gates trigger pulse modes
// R14: pulse type picks active level
// R15: rate mode runs while enabled
// R16: gate synchronised before edge detect
// R17: trigger held one counter clock
module cpo_top
    import cpo_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter pins
    input wire logic [3:0] gate_in,
    input wire logic [3:0] clk_in,
    output logic [3:0] pulse_out
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed
    {
        cpo_cfg_t [CPO_UNITS-1:0] cfg;
        logic [CPO_UNITS-1:0] stop;
        logic [7:0] pre;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } cpo_top_st_t;

    cpo_top_st_t st;
    cpo_top_st_t next_st;
    logic int_tick;
    logic [3:0] g_lvl, g_rise, g_fall, c_rise;
    cpo_stat_t [CPO_UNITS-1:0] stat;
    logic [3:0] pulse_w;
    logic [3:0] unit_sel;
    logic [7:0] reg_off;
    logic hit;

    // unit index and offset within it
    function automatic logic [3:0] unit_of(input logic [7:0] a);
        unit_of = a[7:4];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-unit sync and counter
    // R12: four units
    for (genvar i = 0; i < CPO_UNITS; i++)
    begin : g_unit
        logic tick;
        // R16: gate sync
        cpo_sync u_gate (
            .pclk(pclk),
            .presetn(presetn),
            .pin(gate_in[i]),
            .level(g_lvl[i]),
            .rise(g_rise[i]),
            .fall(g_fall[i])
        );
        // external clock counted on its synchronised rising edge
        cpo_sync u_clk (
            .pclk(pclk),
            .presetn(presetn),
            .pin(clk_in[i]),
            .level(),
            .rise(c_rise[i]),
            .fall()
        );
        // R11: clock source select
        assign tick = st.cfg[i].ext_clk ? c_rise[i] : int_tick;
        cpo_unit u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(st.cfg[i]),
            .stop(st.stop[i]),
            .stat(stat[i]),
            .tick(tick),
            .gate_level(g_lvl[i]),
            .gate_rise(g_rise[i]),
            .gate_fall(g_fall[i]),
            .pulse_out(pulse_w[i])
        );
    end

    // unit outputs are already flopped inside each unit
    assign pulse_out = pulse_w;

    ////////////////////////////////////////////////////////////////////////
    // internal counter clock enable
    assign int_tick = (st.pre == 8'h00);
    assign unit_sel = unit_of(paddr);
    assign reg_off = {4'h0, paddr[3:0]};
    assign hit = (unit_sel < 4'(CPO_UNITS)) && (paddr[1:0] == 2'b00)
        && (reg_off != 8'h0c);

    ////////////////////////////////////////////////////////////////////////
    // apb access, answered in the cycle after setup
    always_comb
    begin
        next_st = st;
        next_st.stop = '0;
        next_st.pre = (st.pre == CPO_INT_DIV - 8'h01) ? 8'h00 : st.pre + 8'h01;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        if (psel && !penable)
        begin
            next_st.ready = 1'b1;
            next_st.err = !hit;
            next_st.rdata = '0;
            if (hit && !pwrite)
            begin
                case (reg_off)
                    CPO_OFF_CTRL: next_st.rdata = {22'h0, stat[unit_sel[1:0]].done,
                        stat[unit_sel[1:0]].running, st.cfg[unit_sel[1:0]].ext_clk,
                        st.cfg[unit_sel[1:0]].pol_high, st.cfg[unit_sel[1:0]].gate,
                        st.cfg[unit_sel[1:0]].mode, st.cfg[unit_sel[1:0]].enable};
                    CPO_OFF_DIV: next_st.rdata = {16'h0, st.cfg[unit_sel[1:0]].divider};
                    CPO_OFF_ACT: next_st.rdata = {16'h0, st.cfg[unit_sel[1:0]].active};
                    default: next_st.rdata = '0;
                endcase
            end
        end
        // write commits at the access edge
        if (psel && penable && st.ready && pwrite && !st.err)
        begin
            case (reg_off)
                CPO_OFF_CTRL:
                begin
                    // R10: software stop ends repeat mode
                    next_st.stop[unit_sel[1:0]] = st.cfg[unit_sel[1:0]].enable
                        & ~pwdata[CPO_F_EN];
                    next_st.cfg[unit_sel[1:0]].enable = pwdata[CPO_F_EN];
                    next_st.cfg[unit_sel[1:0]].mode = cpo_mode_t'(pwdata[CPO_F_MODE +: 2]);
                    next_st.cfg[unit_sel[1:0]].gate = cpo_gate_t'(pwdata[CPO_F_GATE +: 3]);
                    next_st.cfg[unit_sel[1:0]].pol_high = pwdata[CPO_F_POL];
                    next_st.cfg[unit_sel[1:0]].ext_clk = pwdata[CPO_F_CLKSRC];
                end
                CPO_OFF_DIV: next_st.cfg[unit_sel[1:0]].divider = pwdata[15:0];
                CPO_OFF_ACT: next_st.cfg[unit_sel[1:0]].active = pwdata[15:0];
                default: next_st.err = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            // prescaler parks just before wrap so no tick is seen on the release edge
            st.pre <= CPO_INT_DIV - 8'h01;
            for (int k = 0; k < CPO_UNITS; k++)
            begin
                st.cfg[k].divider <= CPO_DIV_RST;
                st.cfg[k].active <= CPO_ACT_RST;
            end
        end
        else
            st <= next_st;
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;

    // access phase is one cycle long
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready not one cycle after setup");
    // internal tick period
    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        int_tick |=> !int_tick [*4] ##1 int_tick)
        else $error("internal tick spacing wrong");
endmodule

// [verification/cpo_far_side.sv]
`timescale 1ns/1ns
// far side of the counters: gate drivers, external clocks, pulse monitor
module cpo_far_side
    import cpo_pkg::*;
(
    // clock
    input wire logic pclk,
    // pins toward the board
    output logic [3:0] gate_in,
    output logic [3:0] clk_in,
    input wire logic [3:0] pulse_out,
    // idle level of each output and external clock run flags
    input wire logic [3:0] idle_lvl,
    input wire logic [3:0] ext_run
);
    // pulse starts, last width and active cycles per unit
    int starts [4];
    int width [4];
    int acts [4];
    int run [4];
    logic [3:0] prev_act = 4'h0;
    int ph = 0;

    initial
    begin
        gate_in = 4'h0;
        clk_in = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // external clock, period 8 pclk; it stands still low while not in use
    always @(posedge pclk)
    begin
        ph <= ph + 1;
        clk_in <= ext_run & {4{ph[2]}};
    end

    // one gate edge: opposite level first, each level held 10 pclk
    // gate held past a counter clock
    task automatic trig(input int u, input bit rise);
        @(posedge pclk);
        gate_in[u] <= ~rise;
        repeat (10) @(posedge pclk);
        gate_in[u] <= rise;
        repeat (10) @(posedge pclk);
    endtask

    // clear the tallies; call only while outputs are idle
    task automatic clr();
        for (int u = 0; u < 4; u++)
        begin
            starts[u] = 0;
            acts[u] = 0;
            run[u] = 0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // monitor: an unknown level counts as active so it never hides
    always @(posedge pclk)
    begin
        for (int u = 0; u < 4; u++)
        begin
            if (pulse_out[u] !== idle_lvl[u])
            begin
                acts[u]++;
                run[u]++;
                if (!prev_act[u])
                    starts[u]++;
            end
            else if (prev_act[u])
            begin
                width[u] = run[u];
                run[u] = 0;
            end
            prev_act[u] = (pulse_out[u] !== idle_lvl[u]);
        end
    end
endmodule

// [verification/counter_pulse_output_modes_bench.sv]
`timescale 1ns/1ns
// self-checking bench for the four pulse output counters
module counter_pulse_output_modes_bench
    import cpo_pkg::*;
;
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
    // apb and pins
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re, pol;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [3:0] gate_in, clk_in, pulse_out, idle, ext;
    int error_cnt, n_tests, dv, ac, u;

    cpo_top cpo_top_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gate_in(gate_in), .clk_in(clk_in), .pulse_out(pulse_out));
    cpo_far_side cpo_far_side_inst(.pclk(pclk), .gate_in(gate_in), .clk_in(clk_in),
        .pulse_out(pulse_out), .idle_lvl(idle), .ext_run(ext));

    always #20 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    // one apb transfer; waits for pready, then a free cycle
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1)
            @(posedge pclk);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // byte address of a unit register
    function automatic logic [7:0] ad(input int n, input logic [7:0] o);
        return 8'(n) * CPO_UNIT_STRIDE + o;
    endfunction

    // control word from its fields
    function automatic logic [31:0] ctl(bit en, cpo_mode_t m, cpo_gate_t g, bit p, bit x);
        return 32'(en) << CPO_F_EN | 32'(m) << CPO_F_MODE | 32'(g) << CPO_F_GATE
            | 32'(p) << CPO_F_POL | 32'(x) << CPO_F_CLKSRC;
    endfunction

    // tolerance window; the gate path and tick phase blur edges a little
    function automatic bit near(input int got, input int exp, input int tol);
        return got >= exp - tol && got <= exp + tol;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog well beyond the planned run
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; idle = 4'h0; ext = 4'h0;
        error_cnt = 0; n_tests = 0;
        void'($urandom(32'haa09));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values of every unit
        for (u = 0; u < 4; u++)
        begin
            apb(0, ad(u, CPO_OFF_CTRL), 0);
            `CHK(rq[9:0], 10'h000)
            apb(0, ad(u, CPO_OFF_DIV), 0);
            `CHK(rq[15:0], CPO_DIV_RST)
            apb(0, ad(u, CPO_OFF_ACT), 0);
            `CHK({re, rq[15:0]}, {1'b0, CPO_ACT_RST})
        end
        // refused offsets: hole, fifth unit, unaligned
        apb(0, 8'h0c, 0);
        `CHK(re, 1'b1)
        apb(1, 8'h40, 32'hffff);
        `CHK(re, 1'b1)
        apb(0, 8'h01, 0);
        `CHK(re, 1'b1)
        // one-shot on each unit, rising gate, random polarity and length
        for (u = 0; u < 4; u++)
        begin
            pol = 1'($urandom);
            dv = 2 + $urandom % 5;
            apb(1, ad(u, CPO_OFF_DIV), 32'(dv));
            apb(1, ad(u, CPO_OFF_CTRL), ctl(1, CPO_ONESHOT, CPO_GATE_RISE, pol, 0));
            idle[u] <= ~pol;
            repeat (10) @(posedge pclk);
            `CHK(pulse_out[u], ~pol)
            cpo_far_side_inst.clr();
            cpo_far_side_inst.trig(u, 1);
            repeat (dv * 5 + 20) @(posedge pclk);
            `CHK(cpo_far_side_inst.starts[u], 1)
            `CHK(near(cpo_far_side_inst.width[u], dv * 5, 5), 1'b1)
            cpo_far_side_inst.trig(u, 1);
            cpo_far_side_inst.trig(u, 1);
            `CHK(cpo_far_side_inst.starts[u], 1)
            apb(0, ad(u, CPO_OFF_CTRL), 0);
            `CHK(rq[CPO_F_DONE], 1'b1)
            `CHK(cpo_far_side_inst.starts[(u + 1) % 4], 0)
        end
        // repeat mode, falling gate; a rising edge must not fire
        u = $urandom % 4;
        pol = 1'($urandom);
        apb(1, ad(u, CPO_OFF_CTRL), 0);
        // park the gate low while disabled so enabling sees no falling edge
        cpo_far_side_inst.trig(u, 0);
        apb(1, ad(u, CPO_OFF_DIV), 32'd8);
        apb(1, ad(u, CPO_OFF_CTRL), ctl(1, CPO_REPEAT, CPO_GATE_FALL, pol, 0));
        idle[u] <= ~pol;
        cpo_far_side_inst.clr();
        cpo_far_side_inst.trig(u, 1);
        repeat (3)
        begin
            cpo_far_side_inst.trig(u, 0);
            repeat (60) @(posedge pclk);
        end
        `CHK(cpo_far_side_inst.starts[u], 3)
        `CHK(near(cpo_far_side_inst.width[u], 40, 5), 1'b1)
        // second trigger lands inside the running pulse
        cpo_far_side_inst.trig(u, 0);
        cpo_far_side_inst.trig(u, 0);
        repeat (60) @(posedge pclk);
        `CHK(cpo_far_side_inst.starts[u], 4)
        // repeat on the external clock, rising gate
        ext[u] <= 1'b1;
        apb(1, ad(u, CPO_OFF_DIV), 32'd3);
        apb(1, ad(u, CPO_OFF_CTRL), ctl(1, CPO_REPEAT, CPO_GATE_RISE, pol, 1));
        cpo_far_side_inst.clr();
        cpo_far_side_inst.trig(u, 1);
        repeat (60) @(posedge pclk);
        `CHK(cpo_far_side_inst.starts[u], 1)
        `CHK(near(cpo_far_side_inst.width[u], 24, 10), 1'b1)
        // software stop: later triggers are dropped
        apb(1, ad(u, CPO_OFF_CTRL), ctl(0, CPO_REPEAT, CPO_GATE_RISE, pol, 1));
        ext[u] <= 1'b0;
        cpo_far_side_inst.trig(u, 1);
        repeat (60) @(posedge pclk);
        `CHK(cpo_far_side_inst.starts[u], 1)
        // rate mode with random divider and active count, then disable
        dv = 4 + $urandom % 4;
        ac = 1 + $urandom % (dv - 1);
        apb(1, ad(u, CPO_OFF_ACT), 32'(ac));
        apb(1, ad(u, CPO_OFF_DIV), 32'(dv));
        apb(1, ad(u, CPO_OFF_CTRL), ctl(1, CPO_RATE, CPO_GATE_NONE, 1, 0));
        idle[u] <= 1'b0;
        repeat (40) @(posedge pclk);
        cpo_far_side_inst.clr();
        repeat (400) @(posedge pclk);
        `CHK(near(cpo_far_side_inst.acts[u], 400 * ac / dv, 25), 1'b1)
        apb(1, ad(u, CPO_OFF_CTRL), ctl(0, CPO_RATE, CPO_GATE_NONE, 1, 0));
        repeat (20) @(posedge pclk);
        cpo_far_side_inst.clr();
        repeat (100) @(posedge pclk);
        `CHK(cpo_far_side_inst.acts[u], 0)
        // level gates: a closed high gate holds rate output idle, a low gate lets it run
        cpo_far_side_inst.trig(u, 0);
        apb(1, ad(u, CPO_OFF_CTRL), ctl(1, CPO_RATE, CPO_GATE_HIGH, 1, 0));
        cpo_far_side_inst.clr();
        repeat (100) @(posedge pclk);
        `CHK(cpo_far_side_inst.acts[u], 0)
        apb(1, ad(u, CPO_OFF_CTRL), ctl(1, CPO_RATE, CPO_GATE_LOW, 1, 0));
        repeat (100) @(posedge pclk);
        `CHK(cpo_far_side_inst.acts[u] > 0, 1'b1)
        results();
    end
endmodule
